// ### rtl/jid_params.svh
/*
 Constants of the test access port instruction decoder: instruction codes,
 chain lengths, capture patterns and the identification value.
 Assumes nothing beyond being included by the modules that use it; the package does not include it.
*/
`ifndef JID_PARAMS_SVH
`define JID_PARAMS_SVH

`define JID_IR_W        10
`define JID_IR_SAMPLE   10'h005
`define JID_IR_EXTEST   10'h00F
`define JID_IR_BYPASS   10'h3FF
`define JID_IR_USERCODE 10'h007
`define JID_IR_IDCODE   10'h006
`define JID_IR_HIGHZ    10'h00B
`define JID_IR_CLAMP    10'h00A
`define JID_IR_RECONF   10'h001
`define JID_IR_CFGLOAD  10'h002
`define JID_IR_CAPTURE  10'h001

`define JID_NPIN        8
`define JID_LA_W        8
`define JID_CFG_W       8
`define JID_DR_W        32
`define JID_BSR_W       16

`define JID_LEN_BYPASS  6'd1
`define JID_LEN_ID      6'd32
`define JID_LEN_BSR     6'd16
`define JID_LEN_SAMPLE  6'd24
`define JID_LEN_CFGLOAD 6'd8

// arbitrary identification value
`define JID_IDCODE      32'h0000_1001

`endif

// ### rtl/jid_pkg.sv
/*
 Types of the test access port instruction decoder.
 Assumes nothing; it does not include jid_params.svh.
*/
package jid_pkg;
    typedef enum logic [3:0] {
        JID_TLR   = 4'b0000,
        JID_RTI   = 4'b0001,
        JID_SELDR = 4'b0010,
        JID_CAPDR = 4'b0011,
        JID_SHDR  = 4'b0100,
        JID_EX1DR = 4'b0101,
        JID_PSDR  = 4'b0110,
        JID_EX2DR = 4'b0111,
        JID_UPDR  = 4'b1000,
        JID_SELIR = 4'b1001,
        JID_CAPIR = 4'b1010,
        JID_SHIR  = 4'b1011,
        JID_EX1IR = 4'b1100,
        JID_PSIR  = 4'b1101,
        JID_EX2IR = 4'b1110,
        JID_UPIR  = 4'b1111
    } jid_tap_t;
endpackage

// ### rtl/jid_buf2.sv
/*
 Two-entry buffer with valid and ready on both sides.
 Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module jid_buf2 #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    typedef struct packed {
        logic [1:0]   cnt;
        logic [W-1:0] d0;
        logic [W-1:0] d1;
    } jid_buf_t;

    jid_buf_t s;
    jid_buf_t next_s;
    logic     push;
    logic     pop;

    assign in_ready  = (s.cnt != 2'h2);
    assign out_valid = (s.cnt != 2'h0);
    assign out_data  = s.d0;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb begin
        next_s = s;
        if (pop) begin
            next_s.d0 = s.d1;
        end
        // entry 0 takes the word when it is or becomes the head
        if (push) begin
            if (s.cnt == 2'h0 || (s.cnt == 2'h1 && pop)) begin
                next_s.d0 = in_data;
            end else begin
                next_s.d1 = in_data;
            end
        end
        next_s.cnt = s.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule

// ### rtl/jid_tap.sv
/*
 Test access port with 10-bit instruction decode, bypass, user code,
 identification, boundary scan, analyzer snapshot and configuration stream.
 Assumes tck, tms, tdi and pin_in come from outside the clk domain, tck well
 below clk/4; core_out, core_oe, usercode, la_* and cfg_ready are on clk.
*/
// Operation
// - Sample/preload captures all pin levels and lets a pattern be preloaded for the pins.
// - External test drives the scanned pattern onto the pins and captures the pin inputs.
// - Bypass puts one flip-flop between tdi and tdo while the core runs on.
// - User code puts the 32-bit user code register between tdi and tdo.
// - Identification puts the identification register between tdi and tdo.
// - High-impedance routes through bypass and releases every pin.
// - Clamp routes through bypass and holds each pin at the boundary register value.
// - The reconfiguration instruction pulses the internal request low, pin untouched.
// - The configuration load instruction streams configuration bytes in through the port.
// - Internal signals are snapshot at full speed and read back under sample.
`timescale 1ns/1ps
`include "jid_params.svh"
module jid_tap (
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic                  tck,
    input  wire logic                  tms,
    input  wire logic                  tdi,
    output logic                       tdo,
    output logic                       tdo_oe,
    input  wire logic [`JID_NPIN-1:0]  pin_in,
    output logic [`JID_NPIN-1:0]       pin_out,
    output logic [`JID_NPIN-1:0]       pin_oe,
    input  wire logic [`JID_NPIN-1:0]  core_out,
    input  wire logic [`JID_NPIN-1:0]  core_oe,
    output logic [`JID_NPIN-1:0]       core_in,
    input  wire logic [31:0]           usercode,
    input  wire logic [`JID_LA_W-1:0]  la_probe,
    input  wire logic                  la_trigger,
    output logic                       la_hold,
    output logic                       config_request_n,
    output logic                       cfg_wait,
    output logic                       cfg_valid,
    input  wire logic                  cfg_ready,
    output logic [`JID_CFG_W-1:0]      cfg_data
);
    typedef struct packed {
        logic                   tck_s1;
        logic                   tck_s2;
        logic                   tck_d;
        logic                   tms_s1;
        logic                   tms_s2;
        logic                   tdi_s1;
        logic                   tdi_s2;
        logic [`JID_NPIN-1:0]   pin_s1;
        logic [`JID_NPIN-1:0]   pin_s2;
        jid_pkg::jid_tap_t      tap;
        logic [`JID_IR_W-1:0]   ir;
        logic [`JID_IR_W-1:0]   ir_sh;
        logic [`JID_DR_W-1:0]   dr;
        logic [`JID_BSR_W-1:0]  bsr;
        logic                   tdo;
        logic                   tdo_oe;
        logic [`JID_NPIN-1:0]   pout;
        logic [`JID_NPIN-1:0]   poe;
        logic                   cfg_n;
        logic                   push;
        logic [`JID_LA_W-1:0]   la;
        logic                   la_hold;
    } jid_state_t;

    jid_state_t s;
    jid_state_t next_s;
    logic       buf_ready;
    logic       hold;
    logic       act;
    logic       fall;

    function automatic logic [5:0] dr_len(input logic [`JID_IR_W-1:0] ir);
        unique case (ir)
            `JID_IR_SAMPLE:                   dr_len = `JID_LEN_SAMPLE;
            `JID_IR_EXTEST:                   dr_len = `JID_LEN_BSR;
            `JID_IR_USERCODE, `JID_IR_IDCODE: dr_len = `JID_LEN_ID;
            `JID_IR_CFGLOAD:                  dr_len = `JID_LEN_CFGLOAD;
            default:                          dr_len = `JID_LEN_BYPASS;
        endcase
    endfunction

    function automatic jid_pkg::jid_tap_t tap_next(input jid_pkg::jid_tap_t t,
                                                   input logic m);
        unique case (t)
            jid_pkg::JID_TLR:   tap_next = m ? jid_pkg::JID_TLR   : jid_pkg::JID_RTI;
            jid_pkg::JID_RTI:   tap_next = m ? jid_pkg::JID_SELDR : jid_pkg::JID_RTI;
            jid_pkg::JID_SELDR: tap_next = m ? jid_pkg::JID_SELIR : jid_pkg::JID_CAPDR;
            jid_pkg::JID_CAPDR: tap_next = m ? jid_pkg::JID_EX1DR : jid_pkg::JID_SHDR;
            jid_pkg::JID_SHDR:  tap_next = m ? jid_pkg::JID_EX1DR : jid_pkg::JID_SHDR;
            jid_pkg::JID_EX1DR: tap_next = m ? jid_pkg::JID_UPDR  : jid_pkg::JID_PSDR;
            jid_pkg::JID_PSDR:  tap_next = m ? jid_pkg::JID_EX2DR : jid_pkg::JID_PSDR;
            jid_pkg::JID_EX2DR: tap_next = m ? jid_pkg::JID_UPDR  : jid_pkg::JID_SHDR;
            jid_pkg::JID_UPDR:  tap_next = m ? jid_pkg::JID_SELDR : jid_pkg::JID_RTI;
            jid_pkg::JID_SELIR: tap_next = m ? jid_pkg::JID_TLR   : jid_pkg::JID_CAPIR;
            jid_pkg::JID_CAPIR: tap_next = m ? jid_pkg::JID_EX1IR : jid_pkg::JID_SHIR;
            jid_pkg::JID_SHIR:  tap_next = m ? jid_pkg::JID_EX1IR : jid_pkg::JID_SHIR;
            jid_pkg::JID_EX1IR: tap_next = m ? jid_pkg::JID_UPIR  : jid_pkg::JID_PSIR;
            jid_pkg::JID_PSIR:  tap_next = m ? jid_pkg::JID_EX2IR : jid_pkg::JID_PSIR;
            jid_pkg::JID_EX2IR: tap_next = m ? jid_pkg::JID_UPIR  : jid_pkg::JID_SHIR;
            jid_pkg::JID_UPIR:  tap_next = m ? jid_pkg::JID_SELDR : jid_pkg::JID_RTI;
        endcase
    endfunction

    // a byte not yet taken by the buffer freezes the port; tck edges wait
    assign hold = s.push & ~buf_ready;
    assign act  = s.tck_s2 & ~s.tck_d & ~hold;
    assign fall = ~s.tck_s2 & s.tck_d & ~hold;

    always_comb begin
        next_s        = s;
        next_s.tck_s1 = tck;
        next_s.tck_s2 = s.tck_s1;
        next_s.tck_d  = hold ? s.tck_d : s.tck_s2;
        next_s.tms_s1 = tms;
        next_s.tms_s2 = s.tms_s1;
        next_s.tdi_s1 = tdi;
        next_s.tdi_s2 = s.tdi_s1;
        next_s.pin_s1 = pin_in;
        next_s.pin_s2 = s.pin_s1;
        next_s.cfg_n  = 1'b1;
        if (s.push && buf_ready) begin
            next_s.push = 1'b0;
        end
        if (!s.la_hold) begin
            next_s.la = la_probe;
        end
        if (act) begin
            unique case (s.tap)
                jid_pkg::JID_TLR: begin
                    next_s.ir = `JID_IR_IDCODE;
                end
                jid_pkg::JID_CAPIR: begin
                    next_s.ir_sh = `JID_IR_CAPTURE;
                end
                jid_pkg::JID_SHIR: begin
                    next_s.ir_sh = {s.tdi_s2, s.ir_sh[`JID_IR_W-1:1]};
                end
                jid_pkg::JID_UPIR: begin
                    next_s.ir = s.ir_sh;
                    if (s.ir_sh == `JID_IR_RECONF) begin
                        next_s.cfg_n = 1'b0;
                    end
                end
                jid_pkg::JID_CAPDR: begin
                    unique case (s.ir)
                        `JID_IR_SAMPLE: begin
                            next_s.dr = {8'h00, s.la, core_oe, s.pin_s2};
                            next_s.la_hold = 1'b0;
                        end
                        `JID_IR_EXTEST:   next_s.dr = {16'h0000, s.poe, s.pin_s2};
                        `JID_IR_USERCODE: next_s.dr = usercode;
                        `JID_IR_IDCODE:   next_s.dr = `JID_IDCODE;
                        default:          next_s.dr = '0;
                    endcase
                end
                jid_pkg::JID_SHDR: begin
                    for (int i = 0; i < `JID_DR_W; i++) begin
                        if (i == int'(dr_len(s.ir)) - 1) begin
                            next_s.dr[i] = s.tdi_s2;
                        end else if (i < `JID_DR_W - 1) begin
                            next_s.dr[i] = s.dr[i+1];
                        end else begin
                            next_s.dr[i] = 1'b0;
                        end
                    end
                end
                jid_pkg::JID_UPDR: begin
                    if (s.ir == `JID_IR_SAMPLE || s.ir == `JID_IR_EXTEST) begin
                        next_s.bsr = s.dr[`JID_BSR_W-1:0];
                    end
                    if (s.ir == `JID_IR_CFGLOAD) begin
                        next_s.push = 1'b1;
                    end
                end
                default: begin
                end
            endcase
            next_s.tap = tap_next(s.tap, s.tms_s2);
        end
        // trigger wins over the rearm in the same cycle
        if (la_trigger) begin
            next_s.la_hold = 1'b1;
        end
        if (fall) begin
            next_s.tdo    = (s.tap == jid_pkg::JID_SHIR) ? s.ir_sh[0] : s.dr[0];
            next_s.tdo_oe = (s.tap == jid_pkg::JID_SHIR) || (s.tap == jid_pkg::JID_SHDR);
        end
        unique case (s.ir)
            `JID_IR_EXTEST, `JID_IR_CLAMP: begin
                next_s.pout = s.bsr[`JID_NPIN-1:0];
                next_s.poe  = s.bsr[`JID_BSR_W-1:`JID_NPIN];
            end
            `JID_IR_HIGHZ: begin
                next_s.pout = core_out;
                next_s.poe  = '0;
            end
            default: begin
                next_s.pout = core_out;
                next_s.poe  = core_oe;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s       <= '0;
            s.tap   <= jid_pkg::JID_TLR;
            s.ir    <= `JID_IR_IDCODE;
            s.cfg_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // the buffer lets the consumer stall without dropping a byte
    jid_buf2 #(.W(`JID_CFG_W)) jid_buf2_i (
        .clk       (clk),
        .resetn    (resetn),
        .in_valid  (s.push),
        .in_ready  (buf_ready),
        .in_data   (s.dr[`JID_CFG_W-1:0]),
        .out_valid (cfg_valid),
        .out_ready (cfg_ready),
        .out_data  (cfg_data)
    );

    assign tdo              = s.tdo;
    assign tdo_oe           = s.tdo_oe;
    assign pin_out          = s.pout;
    assign pin_oe           = s.poe;
    assign core_in          = s.pin_s2;
    assign la_hold          = s.la_hold;
    assign config_request_n = s.cfg_n;
    assign cfg_wait         = hold;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_sample_upd;
        act && s.tap == jid_pkg::JID_UPDR && s.ir == `JID_IR_SAMPLE
            |=> s.bsr == $past(s.dr[`JID_BSR_W-1:0]);
    endproperty
    a_sample_upd: assert property (p_sample_upd) else $error("preload lost");
    property p_extest_pins;
        s.ir == `JID_IR_EXTEST ##1 s.ir == `JID_IR_EXTEST
            |-> pin_oe == $past(s.bsr[`JID_BSR_W-1:`JID_NPIN]);
    endproperty
    a_extest_pins: assert property (p_extest_pins) else $error("extest oe");
    property p_bypass;
        act && s.tap == jid_pkg::JID_SHDR && s.ir == `JID_IR_BYPASS
            |=> s.dr[0] == $past(s.tdi_s2);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass bit");
    property p_usercode;
        act && s.tap == jid_pkg::JID_CAPDR && s.ir == `JID_IR_USERCODE
            |=> s.dr == $past(usercode);
    endproperty
    a_usercode: assert property (p_usercode) else $error("usercode capture");
    property p_idcode;
        act && s.tap == jid_pkg::JID_CAPDR && s.ir == `JID_IR_IDCODE
            |=> s.dr == `JID_IDCODE;
    endproperty
    a_idcode: assert property (p_idcode) else $error("idcode capture");
    property p_highz;
        s.ir == `JID_IR_HIGHZ ##1 s.ir == `JID_IR_HIGHZ |-> pin_oe == '0;
    endproperty
    a_highz: assert property (p_highz) else $error("pin driven in highz");
    property p_clamp;
        s.ir == `JID_IR_CLAMP ##1 s.ir == `JID_IR_CLAMP
            |-> pin_out == $past(s.bsr[`JID_NPIN-1:0]);
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp value");
    property p_reconf;
        act && s.tap == jid_pkg::JID_UPIR && s.ir_sh == `JID_IR_RECONF
            |=> !config_request_n ##1 config_request_n;
    endproperty
    a_reconf: assert property (p_reconf) else $error("reconfig pulse");
    property p_cfgload;
        act && s.tap == jid_pkg::JID_UPDR && s.ir == `JID_IR_CFGLOAD |=> s.push;
    endproperty
    a_cfgload: assert property (p_cfgload) else $error("config byte not queued");
    // the snapshot taken in the trigger cycle itself may still differ from the one before
    property p_la;
        la_trigger |=> la_hold ##1 $stable(s.la);
    endproperty
    a_la: assert property (p_la) else $error("snapshot not frozen");
    property p_ir;
        act && s.tap == jid_pkg::JID_UPIR |=> s.ir == $past(s.ir_sh);
    endproperty
    a_ir: assert property (p_ir) else $error("instruction not updated");
endmodule

// ### test/jid_host.sv
/*
 Behavioural scan controller: drives tck, tms, tdi and reads tdo.
 Assumes the device freezes its port while cfg_wait is high.
*/
`timescale 1ns/1ps
module jid_host (
    input  wire logic cfg_wait,
    input  wire logic tdo,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      hung
);
    initial begin
        tck = 1'h0;
        tms = 1'h1;
        tdi = 1'h0;
        hung = 1'h0;
    end
    // edges are lost while the device is full
    task automatic hold_off;
        int n;
        n = 0;
        while (cfg_wait === 1'h1 && n < 4000) begin
            #5;
            n++;
        end
        if (n == 4000) hung = 1'h1;
    endtask
    // tck stands low between cycles; tdo taken just before the rise
    task automatic tick(input logic m, input logic sh, input logic d, output logic q);
        hold_off();
        tms = m;
        tdi = sh ? d : ~tdi; // released line does not keep its level
        #24;
        hold_off();
        q = tdo;
        tck = 1'h1;
        #24;
        tck = 1'h0;
    endtask
    // off the clk edge so pin changes never race the synchroniser
    task automatic reset_tap;
        logic q;
        #1.3;
        repeat (6) tick(1'h1, 1'h0, 1'h0, q);
        tick(1'h0, 1'h0, 1'h0, q);
    endtask
    // from idle through capture, shift, update and back to idle
    task automatic scan(input logic ir, input int len, input logic [31:0] din,
                        output logic [31:0] dout);
        logic q;
        dout = 32'h0;
        #1.3;
        tick(1'h1, 1'h0, 1'h0, q);
        if (ir) tick(1'h1, 1'h0, 1'h0, q);
        tick(1'h0, 1'h0, 1'h0, q);
        tick(1'h0, 1'h0, 1'h0, q);
        for (int i = 0; i < len; i++) begin
            tick(i == len - 1, 1'h1, din[i], q);
            dout[i] = q;
        end
        tick(1'h1, 1'h0, 1'h0, q);
        tick(1'h0, 1'h0, 1'h0, q);
    endtask
endmodule

// ### test/jid_tap_tb.sv
/*
 Self-checking bench of the scan port instruction decoder.
 Assumes jid_host plays the scan controller and jid_tap is the device.
*/
`timescale 1ns/1ps
`include "jid_params.svh"
module jid_tap_tb;
    logic        clk = 1'h0;
    logic        resetn = 1'h0;
    logic        tck, tms, tdi, tdo, tdo_oe, hung, la_hold, config_request_n;
    logic        cfg_wait, cfg_valid, la_trigger = 1'h0, cfg_ready = 1'h0;
    logic [7:0]  pin_in = 8'h00, core_out = 8'h00, core_oe = 8'h00, la_probe = 8'h00;
    logic [7:0]  pin_out, pin_oe, core_in, cfg_data;
    logic [31:0] usercode = 32'h0, o;
    int          mismatches = 0, comparisons = 0, lows = 0, shs = 0;
    logic [7:0]  got[$];

    jid_tap jid_tap_i (.clk(clk), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi),
        .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .core_out(core_out), .core_oe(core_oe), .core_in(core_in), .usercode(usercode),
        .la_probe(la_probe), .la_trigger(la_trigger), .la_hold(la_hold),
        .config_request_n(config_request_n), .cfg_wait(cfg_wait), .cfg_valid(cfg_valid),
        .cfg_ready(cfg_ready), .cfg_data(cfg_data));
    jid_host jid_host_i (.cfg_wait(cfg_wait), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi),
        .hung(hung));

    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (config_request_n === 1'h0) lows <= lows + 1;
        if (tdo_oe === 1'h1) shs <= shs + 1;
        if (cfg_valid === 1'h1 && cfg_ready === 1'h1) got.push_back(cfg_data);
    end

    task automatic close_out;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wclk(input int n);
        repeat (n) @(posedge clk);
    endtask
    // scans start on a clk edge so the host's pin changes stay off it
    task automatic ld(input logic [9:0] c);
        wclk(1);
        jid_host_i.scan(1'h1, 10, 32'(c), o);
        chk(32'(o[9:0]), 32'(`JID_IR_CAPTURE));
    endtask
    task automatic dr(input int n, input logic [31:0] d);
        wclk(1);
        jid_host_i.scan(1'h0, n, d, o);
    endtask
    // single cell: first bit out is the captured zero, then tdi one cycle late
    task automatic byp(input logic [7:0] d);
        dr(8, 32'(d));
        chk(32'(o[7:0]), 32'({d[6:0], 1'h0}));
    endtask

    task automatic t_id;
        jid_host_i.reset_tap();
        dr(32, 32'h0);
        chk(o, `JID_IDCODE);
        chk(32'(shs > 0), 32'h1);
        chk(32'(tdo_oe), 32'h0);
    endtask
    task automatic t_user;
        wclk(1);
        usercode <= 32'hC3A5_5A3C;
        ld(`JID_IR_USERCODE);
        dr(32, 32'h0);
        chk(o, 32'hC3A5_5A3C);
    endtask
    task automatic t_bypass;
        wclk(1);
        core_out <= 8'h5A;
        core_oe <= 8'hF0;
        ld(`JID_IR_BYPASS);
        byp(8'hB6);
        chk(32'({pin_oe, pin_out}), 32'h0000_F05A);
    endtask
    task automatic t_sample;
        wclk(1);
        pin_in <= 8'h96;
        la_probe <= 8'h3E;
        wclk(4);
        la_trigger <= 1'h1;
        wclk(1);
        la_trigger <= 1'h0;
        wclk(4);
        la_probe <= 8'h00;
        wclk(2);
        chk(32'(la_hold), 32'h1);
        chk(32'(core_in), 32'h96);
        ld(`JID_IR_SAMPLE);
        dr(24, 32'h0000_FF3C);
        chk(o, 32'h003E_F096);
        chk(32'(la_hold), 32'h0);
    endtask
    task automatic t_clamp;
        ld(`JID_IR_CLAMP);
        wclk(2);
        chk(32'({pin_oe, pin_out}), 32'h0000_FF3C);
        byp(8'h4D);
    endtask
    task automatic t_highz;
        ld(`JID_IR_HIGHZ);
        wclk(2);
        chk(32'(pin_oe), 32'h0);
        byp(8'hD2);
    endtask
    // capture sees the enables that the preloaded pattern drives
    task automatic t_extest;
        wclk(1);
        pin_in <= 8'h69;
        ld(`JID_IR_EXTEST);
        dr(16, 32'h0000_0FC3);
        chk(32'(o[15:0]), 32'hFF69);
        wclk(2);
        chk(32'({pin_oe, pin_out}), 32'h0000_0FC3);
    endtask
    task automatic t_reconf;
        int n0;
        n0 = lows;
        ld(`JID_IR_RECONF);
        wclk(4);
        chk(32'(lows - n0), 32'h1);
        byp(8'h39);
    endtask
    // third byte finds the buffer full while the receiver stalls
    task automatic t_cfgload;
        logic [7:0] tbl[3] = '{8'h81, 8'hA3, 8'h5C};
        int n;
        got.delete();
        ld(`JID_IR_CFGLOAD);
        fork
            for (int b = 0; b < 3; b++) dr(8, 32'(tbl[b]));
            begin
                n = 0;
                while (cfg_wait !== 1'h1 && n < 3000) begin
                    wclk(1);
                    n++;
                end
                if (n == 3000) begin
                    mismatches++;
                    $display("unexpected at %0t: no back-pressure", $time);
                    close_out();
                end
                chk(32'({cfg_valid, cfg_data}), 32'h181);
                wclk(20);
                chk(32'({cfg_valid, cfg_data, cfg_wait}), 32'h303);
                cfg_ready <= 1'h1;
            end
        join
        wclk(8);
        chk(32'(got.size()), 32'h3);
        for (int b = 0; b < 3 && b < got.size(); b++) chk(32'(got[b]), 32'(tbl[b]));
    endtask

    initial begin
        wclk(2);
        resetn <= 1'h1;
        wclk(2);
        t_id();
        t_user();
        t_bypass();
        t_sample();
        t_clamp();
        t_highz();
        t_extest();
        t_reconf();
        t_cfgload();
        chk(32'(hung), 32'h0);
        close_out();
    end
endmodule
